// ==== bgfs_top.sv ====
// Banked general-purpose register file with system and user stack pointers
`timescale 1ns/1ps
module bgfs_top (
    // Clock and reset
    input  wire logic                         CLOCK_I,
    input  wire logic                         RST_N_I,
    // Register access by number or short name
    input  wire logic                         REG_RD_I,
    input  wire logic                         REG_WR_I,
    input  wire bgfs_pkg::bgfs_size_type      REG_SIZE_I,
    input  wire logic [bgfs_pkg::REG_W-1:0]   REG_SEL_I,
    input  wire logic                         REG_ALIAS_I,
    input  wire logic [bgfs_pkg::DATA_W-1:0]  REG_WDATA_I,
    output logic      [bgfs_pkg::DATA_W-1:0]  REG_RDATA_O,
    // Data memory view of the bank area
    input  wire logic                         MEM_RD_I,
    input  wire logic                         MEM_WR_I,
    input  wire logic [bgfs_pkg::ADDR_W-1:0]  MEM_ADDR_I,
    input  wire logic [bgfs_pkg::BYTE_W-1:0]  MEM_WDATA_I,
    input  wire logic                         HIGH_MAP_I,
    output logic                              MEM_HIT_O,
    output logic      [bgfs_pkg::BYTE_W-1:0]  MEM_RDATA_O,
    // Status word and bank selection
    input  wire logic                         PSW_WR_I,
    input  wire logic [bgfs_pkg::PSW_W-1:0]   PSW_WDATA_I,
    input  wire logic                         BANK_SEL_I,
    input  wire logic [bgfs_pkg::BANK_W-1:0]  BANK_NUM_I,
    output logic      [bgfs_pkg::PSW_W-1:0]   PSW_O,
    output logic      [bgfs_pkg::BANK_W-1:0]  BANK_O,
    // System stack
    input  wire logic                         SP_LOAD_I,
    input  wire logic [bgfs_pkg::SP_W-1:0]    SP_WDATA_I,
    input  wire logic                         SP_PUSH_I,
    input  wire logic                         SP_POP_I,
    input  wire logic [1:0]                   SP_BYTES_I,
    output logic      [bgfs_pkg::SP_W-1:0]    SP_O,
    output logic      [bgfs_pkg::SP_W-1:0]    STACK_ADDR_O,
    output logic                              SP_VALID_O,
    // Interrupt entry and return
    input  wire logic                         NMI_REQ_I,
    input  wire logic                         IRQ_REQ_I,
    input  wire logic                         RETURN_I,
    input  wire logic [bgfs_pkg::PSW_W-1:0]   RETURN_PSW_I,
    output logic                              NMI_ACK_O,
    output logic                              IRQ_ACK_O,
    output logic                              STACK_WR_O,
    output logic      [bgfs_pkg::PSW_W-1:0]   STACK_WDATA_O,
    // Context switch
    input  wire logic                         CTX_SWITCH_I,
    input  wire logic [bgfs_pkg::PC_W-1:0]    CTX_PC_I,
    input  wire logic [bgfs_pkg::BANK_W-1:0]  CTX_BANK_I,
    // Loop and string counters
    input  wire logic                         DEC_BRANCH_NONZERO_I,
    input  wire logic                         DEC_BRANCH_NONZERO_HIGH_I,
    input  wire logic                         STR_STEP_I,
    output logic                              BRANCH_O,
    output logic                              COUNT_ZERO_O,
    // User stack
    input  wire logic                         UPUSH_I,
    input  wire logic                         UPOP_I,
    output logic      [bgfs_pkg::SP_W-1:0]    USTACK_ADDR_O
);
    import bgfs_pkg::*;

    logic [PSW_W-1:0]               psw_reg;
    logic [BANK_W-1:0]              bank_reg;
    logic [SP_W-1:0]                sp_reg;
    logic                           sp_valid_reg;
    logic                           op_ctx;
    logic                           op_reg;
    logic                           op_dec_branch_nonzero;
    logic                           op_str;
    logic                           op_user;
    logic                           op_mem;
    logic                           any_op;
    logic                           mem_hit;
    logic                           alias_bank_select;
    logic [ADDR_W-1:0]              map_base;
    logic [2:0]                     pair;
    logic [LANES-1:0][REG_W-1:0]    lane_reg;
    logic [LANES-1:0][RAM_AW-1:0]   ram_addr;
    logic [LANES-1:0]               lane_we;
    logic [LANES-1:0][BYTE_W-1:0]   lane_wd;
    logic [LANES-1:0][BYTE_W-1:0]   rd;
    logic [1:0]                     ext_sel;
    logic                           ext_we;
    logic [BYTE_W-1:0]              ext_wd;
    logic [BYTE_W-1:0]              ext_rd;
    logic [BYTE_W-1:0]              ext_reg [NUM_BANKS][EXT_REGS];
    logic [SP_W-1:0]                uptr;
    logic [SP_W-1:0]                uptr_next;
    logic [BYTE_W-1:0]              count_next;
    logic                           nmi_take;
    logic                           irq_take;

    assign alias_bank_select = psw_reg[PSW_RSS_BIT];

    // Short names only move when the caller asks for them
    function automatic logic [REG_W-1:0] alias_byte(
        input logic [REG_W-1:0] r, input logic en);
        logic [REG_W-1:0] res;
        res = r;
        if (en && r < ALIAS_BYTE_OFS) begin
            res = r + ALIAS_BYTE_OFS;  // RQ14 RQ24
        end
        return res;
    endfunction : alias_byte

    function automatic logic [2:0] alias_pair(
        input logic [2:0] p, input logic en);
        logic [2:0] res;
        res = p;
        if (en && p < ALIAS_PAIR_OFS) begin
            res = p + ALIAS_PAIR_OFS;  // RQ14 RQ24
        end
        return res;
    endfunction : alias_pair

    // Data memory window, relocated under the high map
    always_comb begin
        map_base = LOW_MAP_BASE;
        if (HIGH_MAP_I) begin
            map_base = LOW_MAP_BASE + HIGH_MAP_OFFSET;  // RQ13
        end
        mem_hit = MEM_ADDR_I[ADDR_W-1:RAM_AW] ==
                  map_base[ADDR_W-1:RAM_AW];  // RQ12
    end

    // One operation per cycle, fixed priority
    always_comb begin
        any_op  = CTX_SWITCH_I || REG_RD_I || REG_WR_I || DEC_BRANCH_NONZERO_I ||
                  STR_STEP_I || UPUSH_I || UPOP_I;
        op_ctx  = CTX_SWITCH_I;
        op_reg  = !op_ctx && (REG_RD_I || REG_WR_I);
        op_dec_branch_nonzero = !op_ctx && !op_reg && DEC_BRANCH_NONZERO_I;
        op_str  = !op_ctx && !op_reg && !DEC_BRANCH_NONZERO_I && STR_STEP_I;
        op_user = !op_ctx && !op_reg && !DEC_BRANCH_NONZERO_I && !STR_STEP_I &&
                  (UPUSH_I || UPOP_I);
        op_mem  = !any_op && (MEM_RD_I || MEM_WR_I) && mem_hit;
    end

    // Lane addressing for the chosen operation
    always_comb begin
        lane_reg = '0;
        pair     = PAIR_AX;
        ext_sel  = PTR_USER;
        if (op_ctx) begin
            lane_reg[0] = {PAIR_CTX_LOW, 1'b0};  // RQ18
            lane_reg[1] = {PAIR_CTX_LOW, 1'b1};
            lane_reg[2] = {PAIR_CTX_HIGH, 1'b0};  // RQ19
            lane_reg[3] = {PAIR_CTX_HIGH, 1'b1};
        end else if (op_reg) begin
            case (REG_SIZE_I)
                SZ_BYTE: begin
                    lane_reg[0] = alias_byte(REG_SEL_I, REG_ALIAS_I && alias_bank_select);  // RQ15
                end
                SZ_PAIR: begin
                    pair = alias_pair(REG_SEL_I[2:0], REG_ALIAS_I && alias_bank_select);  // RQ6
                    lane_reg[0] = {pair, 1'b0};  // RQ26
                    lane_reg[1] = {pair, 1'b1};
                end
                SZ_PTR: begin
                    pair = PAIR_PTR_BASE | {1'b0, REG_SEL_I[1:0]};  // RQ7
                    ext_sel = REG_SEL_I[1:0];
                    lane_reg[0] = {pair, 1'b0};
                    lane_reg[1] = {pair, 1'b1};
                end
                default: begin
                    pair = alias_pair(PAIR_AX, REG_ALIAS_I && alias_bank_select);  // RQ17
                    lane_reg[0] = {PAIR_DE, 1'b0};
                    lane_reg[1] = {PAIR_DE, 1'b1};
                    lane_reg[2] = {pair, 1'b0};
                    lane_reg[3] = {pair, 1'b1};
                end
            endcase
        end else if (op_dec_branch_nonzero) begin
            lane_reg[0] = alias_byte(DEC_BRANCH_NONZERO_HIGH_I ? REG_B : REG_C, alias_bank_select);  // RQ20
        end else if (op_str) begin
            lane_reg[0] = alias_byte(REG_C, alias_bank_select);  // RQ21
        end else if (op_user) begin
            lane_reg[0] = {PAIR_PTR_BASE | {1'b0, PTR_USER}, 1'b0};  // RQ22
            lane_reg[1] = {PAIR_PTR_BASE | {1'b0, PTR_USER}, 1'b1};
        end
    end

    // Bank 0 sits at the top of the area, Rn at offset n
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_addr
            assign ram_addr[g] = op_mem ? MEM_ADDR_I[RAM_AW-1:0]
                                        : {~bank_reg, lane_reg[g]};  // RQ25
        end
    endgenerate

    assign ext_rd    = ext_reg[bank_reg][ext_sel];
    assign uptr      = {ext_rd, rd[1], rd[0]};
    assign uptr_next = UPUSH_I ? uptr - SP_W'(SP_BYTES_I)
                               : uptr + SP_W'(SP_BYTES_I);
    assign count_next = rd[0] - BYTE_W'(1);

    // Write data and enables for the chosen operation
    always_comb begin
        lane_we = '0;
        lane_wd = '0;
        ext_we  = 1'b0;
        ext_wd  = '0;
        if (op_ctx) begin
            lane_we = '1;
            lane_wd = {psw_reg[PSW_W-1:PSW_KEEP_LSB],
                       CTX_PC_I[PC_W-1:PSW_W],
                       psw_reg[BYTE_W-1:0],
                       CTX_PC_I[PSW_W-1:0]};  // RQ18 RQ19
        end else if (op_reg) begin
            lane_wd = REG_WDATA_I;
            ext_wd  = REG_WDATA_I[2*BYTE_W +: BYTE_W];
            case (REG_SIZE_I)
                SZ_BYTE: lane_we[0] = REG_WR_I;
                SZ_PAIR: lane_we[1:0] = {2{REG_WR_I}};
                SZ_PTR: begin
                    lane_we[1:0] = {2{REG_WR_I}};
                    ext_we = REG_WR_I;  // RQ7
                end
                default: lane_we = {LANES{REG_WR_I}};
            endcase
        end else if (op_dec_branch_nonzero || op_str) begin
            lane_we[0] = 1'b1;
            lane_wd[0] = count_next;  // RQ20 RQ21
        end else if (op_user) begin
            lane_we[1:0] = '1;
            lane_wd[1:0] = uptr_next[2*BYTE_W-1:0];  // RQ22
            ext_we = 1'b1;
            ext_wd = uptr_next[SP_W-1:2*BYTE_W];
        end else if (op_mem) begin
            lane_we[0] = MEM_WR_I;
            lane_wd[0] = MEM_WDATA_I;  // RQ12
        end
    end

    // Banks in RAM; extension bytes kept in flops
    bgfs_ram #(
        .WIDTH (BYTE_W),
        .AW    (RAM_AW),
        .LANES (LANES)
    ) u_ram (
        .clk_i   (CLOCK_I),
        .we_i    (lane_we),
        .addr_i  (ram_addr),
        .wdata_i (lane_wd),
        .rdata_o (rd)
    );  // RQ8

    always_ff @(posedge CLOCK_I) begin
        if (ext_we) begin
            ext_reg[bank_reg][ext_sel] <= ext_wd;  // RQ8
        end
    end

    // Status word and active bank
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            psw_reg  <= PSW_RESET;
            bank_reg <= BANK_RESET;  // RQ10
        end else if (PSW_WR_I) begin
            psw_reg  <= PSW_WDATA_I;
            bank_reg <= PSW_WDATA_I[PSW_RBS_LSB +: BANK_W];
        end else if (RETURN_I) begin
            psw_reg  <= RETURN_PSW_I;  // RQ16
            bank_reg <= RETURN_PSW_I[PSW_RBS_LSB +: BANK_W];
        end else if (BANK_SEL_I) begin
            psw_reg[PSW_RBS_LSB +: BANK_W] <= BANK_NUM_I;  // RQ23
            bank_reg <= BANK_NUM_I;  // RQ9
        end else if (op_ctx) begin
            psw_reg[PSW_RBS_LSB +: BANK_W] <= CTX_BANK_I;  // RQ9
            bank_reg <= CTX_BANK_I;
        end
    end

    assign PSW_O  = psw_reg;
    assign BANK_O = bank_reg;  // RQ11

    // Interrupt acceptance; maskable ones wait for a loaded pointer
    assign nmi_take = NMI_REQ_I;  // RQ5
    assign irq_take = IRQ_REQ_I && !NMI_REQ_I && sp_valid_reg;  // RQ4

    // System stack pointer
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            sp_reg        <= SP_RESET;
            sp_valid_reg  <= 1'b0;  // RQ4
            STACK_ADDR_O  <= SP_RESET;
            STACK_WR_O    <= 1'b0;
            STACK_WDATA_O <= PSW_RESET;
            NMI_ACK_O     <= 1'b0;
            IRQ_ACK_O     <= 1'b0;
        end else begin
            STACK_WR_O <= 1'b0;
            // A pointer load wins the cycle, so nothing is accepted then
            NMI_ACK_O  <= nmi_take && !SP_LOAD_I;  // RQ5
            IRQ_ACK_O  <= irq_take && !SP_LOAD_I;  // RQ4
            if (SP_LOAD_I) begin
                sp_reg       <= SP_WDATA_I;  // RQ1 RQ2
                sp_valid_reg <= 1'b1;
            end else if (nmi_take || irq_take) begin
                sp_reg        <= sp_reg - SP_W'(PSW_PUSH_BYTES);  // RQ3
                STACK_ADDR_O  <= sp_reg - SP_W'(PSW_PUSH_BYTES);
                STACK_WR_O    <= 1'b1;
                STACK_WDATA_O <= psw_reg;  // RQ16
            end else if (RETURN_I) begin
                STACK_ADDR_O <= sp_reg;
                sp_reg       <= sp_reg + SP_W'(PSW_PUSH_BYTES);  // RQ16
            end else if (SP_PUSH_I) begin
                sp_reg       <= sp_reg - SP_W'(SP_BYTES_I);  // RQ3
                STACK_ADDR_O <= sp_reg - SP_W'(SP_BYTES_I);
            end else if (SP_POP_I) begin
                STACK_ADDR_O <= sp_reg;  // RQ3
                sp_reg       <= sp_reg + SP_W'(SP_BYTES_I);
            end
        end
    end

    assign SP_O       = sp_reg;
    assign SP_VALID_O = sp_valid_reg;

    // Read results and counter status
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O   <= '0;
            MEM_RDATA_O   <= '0;
            MEM_HIT_O     <= 1'b0;
            BRANCH_O      <= 1'b0;
            COUNT_ZERO_O  <= 1'b0;
            USTACK_ADDR_O <= SP_RESET;
        end else begin
            MEM_HIT_O <= op_mem;
            BRANCH_O  <= op_dec_branch_nonzero && (count_next != '0);  // RQ20
            if (op_reg && REG_RD_I) begin
                case (REG_SIZE_I)
                    SZ_BYTE: REG_RDATA_O <= DATA_W'(rd[0]);
                    SZ_PAIR: REG_RDATA_O <= DATA_W'({rd[1], rd[0]});
                    SZ_PTR:  REG_RDATA_O <= DATA_W'({ext_rd, rd[1], rd[0]});
                    default: REG_RDATA_O <= rd;  // RQ17
                endcase
            end
            if (op_mem && MEM_RD_I) begin
                MEM_RDATA_O <= rd[0];  // RQ12
            end
            if (op_str) begin
                COUNT_ZERO_O <= (count_next == '0);  // RQ21
            end
            if (op_user) begin
                USTACK_ADDR_O <= UPUSH_I ? uptr_next : uptr;  // RQ22
            end
        end
    end

    // Checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    a_reset_bank: assert property (disable iff (1'b0)
        !RST_N_I |=> BANK_O == BANK_RESET)  // RQ10
        else $error("bank not zero after reset");
    a_push_predec: assert property (
        SP_PUSH_I && !SP_LOAD_I && !NMI_REQ_I && !IRQ_REQ_I && !RETURN_I
        |=> SP_O == $past(SP_O) - SP_W'($past(SP_BYTES_I)) &&
            STACK_ADDR_O == SP_O)  // RQ3
        else $error("push did not pre-decrement");
    a_pop_postinc: assert property (
        SP_POP_I && !SP_PUSH_I && !SP_LOAD_I && !NMI_REQ_I &&
        !IRQ_REQ_I && !RETURN_I
        |=> STACK_ADDR_O == $past(SP_O) &&
            SP_O == $past(SP_O) + SP_W'($past(SP_BYTES_I)))  // RQ3
        else $error("pop did not post-increment");
    a_nmi_undefined: assert property (
        NMI_REQ_I && !SP_VALID_O && !SP_LOAD_I |=> NMI_ACK_O)  // RQ5
        else $error("nmi refused with undefined pointer");
    a_irq_gated: assert property (
        !SP_VALID_O |=> !IRQ_ACK_O)  // RQ4
        else $error("irq accepted before pointer load");
    a_psw_pushed: assert property (
        IRQ_ACK_O || NMI_ACK_O |-> STACK_WR_O &&
        STACK_WDATA_O == $past(PSW_O))  // RQ16
        else $error("status word not pushed on interrupt");
    a_return_psw: assert property (
        RETURN_I && !PSW_WR_I |=> PSW_O == $past(RETURN_PSW_I))  // RQ16
        else $error("status word not restored on return");
    a_bank_select: assert property (
        BANK_SEL_I && !PSW_WR_I && !RETURN_I
        |=> BANK_O == $past(BANK_NUM_I) ##0
            PSW_O[PSW_RBS_LSB +: BANK_W] == BANK_O)  // RQ23
        else $error("bank select not applied");
    a_mem_window: assert property (
        MEM_RD_I && !any_op && !mem_hit |=> !MEM_HIT_O)  // RQ12
        else $error("access outside bank area accepted");

    c_nmi_early: cover property (NMI_REQ_I && !SP_VALID_O ##1 NMI_ACK_O);
    c_ctx_switch: cover property (CTX_SWITCH_I ##1 BANK_O != $past(BANK_O));
    c_dec_branch_nonzero_loop: cover property (DEC_BRANCH_NONZERO_I ##1 BRANCH_O ##1 DEC_BRANCH_NONZERO_I);
    c_user_push: cover property (UPUSH_I && op_user ##1 UPOP_I);
endmodule : bgfs_top

// ==== bgfs_pkg.sv ====
// Constants and types shared by the banked register file
// Behaviour
// RQ1 - 24-bit stack pointer addresses subroutine and interrupt stack
// RQ2 - Software writes zero into pointer upper four bits
// RQ3 - Pointer decrements before push, increments after pop
// RQ4 - Pointer undefined after reset until software loads
// RQ5 - Non-maskable interrupts accepted while pointer undefined
// RQ6 - Sixteen byte registers per bank, pairable
// RQ7 - Four pairs plus extension byte form pointers
// RQ8 - Bank registers except extensions live in RAM
// RQ9 - Eight banks switched by instruction or context switch
// RQ10 - Reset selects bank zero
// RQ11 - Active bank readable in status word field
// RQ12 - Bank area also reachable as data memory
// RQ13 - High map moves bank area up by offset
// RQ14 - Alias bit routes short names to upper registers
// RQ15 - Absolute register numbers ignore the alias bit
// RQ16 - Interrupt pushes status word, return restores it
// RQ17 - Accumulator and offset pair form 32-bit operand
// RQ18 - Context switch saves low program counter word
// RQ19 - Context switch saves upper counter bits and status
// RQ20 - Both counter bytes serve decrement-and-branch loops
// RQ21 - Low counter counts string and difference elements
// RQ22 - Second pointer is a separate user stack pointer
// RQ23 - Three-bit bank field loaded by bank-select operation
// RQ24 - Alias bit picks R1,R0,R3,R2 or R5,R4,R7,R6
// RQ25 - Bank zero on top, Rn at offset n
// RQ26 - Wide accesses touch all bytes at once, low first
package bgfs_pkg;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W    = 3;
    localparam int REG_W     = 4;
    localparam int BYTE_W    = 8;
    localparam int RAM_AW    = 7;
    localparam int LANES     = 4;
    localparam int EXT_REGS  = 4;
    localparam int SP_W      = 24;
    localparam int ADDR_W    = 24;
    localparam int PSW_W     = 16;
    localparam int PC_W      = 20;
    localparam int DATA_W    = 32;
    localparam int PSW_RSS_BIT  = 5;
    localparam int PSW_RBS_LSB  = 12;
    localparam int PSW_KEEP_LSB = 12;
    localparam logic [PSW_W-1:0]  PSW_RESET       = 16'h0000;
    localparam logic [SP_W-1:0]   SP_RESET        = 24'h000000;
    localparam logic [ADDR_W-1:0] LOW_MAP_BASE    = 24'h00FE80;
    localparam logic [ADDR_W-1:0] HIGH_MAP_OFFSET = 24'h0F0000;
    localparam logic [1:0]        PSW_PUSH_BYTES  = 2'h2;
    localparam logic [REG_W-1:0]  REG_C           = 4'h2;
    localparam logic [REG_W-1:0]  REG_B           = 4'h3;
    localparam logic [REG_W-1:0]  ALIAS_BYTE_OFS  = 4'h4;
    localparam logic [2:0]        ALIAS_PAIR_OFS  = 3'h2;
    localparam logic [2:0]        PAIR_AX         = 3'h0;
    localparam logic [2:0]        PAIR_CTX_LOW    = 3'h2;
    localparam logic [2:0]        PAIR_CTX_HIGH   = 3'h3;
    localparam logic [2:0]        PAIR_PTR_BASE   = 3'h4;
    localparam logic [2:0]        PAIR_DE         = 3'h6;
    localparam logic [1:0]        PTR_USER        = 2'h1;
    localparam logic [BANK_W-1:0] BANK_RESET      = 3'h0;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_PAIR = 2'b01,
        SZ_PTR  = 2'b10,
        SZ_WIDE = 2'b11
    } bgfs_size_type;
endpackage : bgfs_pkg

// ==== bgfs_ram.sv ====
// Byte RAM holding all banks, with parallel read and write lanes
`timescale 1ns/1ps
module bgfs_ram #(
    parameter int WIDTH = 8,
    parameter int AW    = 7,
    parameter int LANES = 4
) (
    // Clock
    input  wire logic                        clk_i,
    // Write lanes, higher lane wins on a clash
    input  wire logic [LANES-1:0]            we_i,
    input  wire logic [LANES-1:0][AW-1:0]    addr_i,
    input  wire logic [LANES-1:0][WIDTH-1:0] wdata_i,
    // Read lanes, same addresses
    output logic      [LANES-1:0][WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [2**AW];

    always_ff @(posedge clk_i) begin
        for (int k = 0; k < LANES; k++) begin
            if (we_i[k]) begin
                mem[addr_i[k]] <= wdata_i[k];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_rd
            assign rdata_o[g] = mem[addr_i[g]];
        end
    endgenerate
endmodule : bgfs_ram

// ==== bgfs_cpu_model.sv ====
// Instruction-side model that loads the stack pointer after reset
`timescale 1ns/1ps
module bgfs_cpu_model (
    // Clock and start of the initialization program
    input  wire logic        clk_i,
    input  wire logic        init_i,
    input  wire logic [19:0] base_i,
    // Stack pointer load
    output logic             sp_load_o,
    output logic [23:0]      sp_wdata_o
);
    // Outside a load the data shows the inverse of the load value
    always @(posedge clk_i) begin
        if (init_i) begin
            #1 sp_load_o = 1'b1;
            sp_wdata_o = {4'h0, base_i};
        end else begin
            #1 sp_load_o = 1'b0;
            sp_wdata_o = {4'hF, ~base_i};
        end
    end
endmodule : bgfs_cpu_model

// ==== testbench.sv ====
// Self-checking bench for the banked register file
`timescale 1ns/1ps
module testbench;
    import bgfs_pkg::*;
    typedef struct {
        bgfs_size_type ws;
        logic [3:0]    wn;
        logic [31:0]   wd;
        bgfs_size_type rs;
        logic [3:0]    rn;
        logic [31:0]   ex;
    } bgfs_row_type;
    bgfs_row_type  rows [4];
    bgfs_size_type sz;
    logic          clk = 1'b0;
    logic          rst_n, rd, wr, al, m_rd, m_wr, hi, p_wr, b_sel, push;
    logic          pop, nmi, irq, ret, ctx, dec_branch_nonzero, d_hi, step, upush, upop;
    logic          init, hit, n_ack, i_ack, s_wr, br, zero, sp_ok, sp_ld;
    logic [3:0]    sel;
    logic [31:0]   wd, rdat;
    logic [23:0]   ma, sp, sa, ua, sp_wd;
    logic [15:0]   pw, rp, processor_status_word, s_wd;
    logic [7:0]    mw, mr;
    logic [2:0]    bn, cb, bank;
    logic [1:0]    nb;
    logic [19:0]   pc;
    int            checked = 0;
    int            miscompares = 0;
    bgfs_top uut (
        .CLOCK_I(clk), .RST_N_I(rst_n), .REG_RD_I(rd), .REG_WR_I(wr),
        .REG_SIZE_I(sz), .REG_SEL_I(sel), .REG_ALIAS_I(al),
        .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .MEM_RD_I(m_rd),
        .MEM_WR_I(m_wr), .MEM_ADDR_I(ma), .MEM_WDATA_I(mw), .HIGH_MAP_I(hi),
        .MEM_HIT_O(hit), .MEM_RDATA_O(mr), .PSW_WR_I(p_wr), .PSW_WDATA_I(pw),
        .BANK_SEL_I(b_sel), .BANK_NUM_I(bn), .PSW_O(processor_status_word), .BANK_O(bank),
        .SP_LOAD_I(sp_ld), .SP_WDATA_I(sp_wd), .SP_PUSH_I(push),
        .SP_POP_I(pop), .SP_BYTES_I(nb), .SP_O(sp), .STACK_ADDR_O(sa),
        .SP_VALID_O(sp_ok), .NMI_REQ_I(nmi), .IRQ_REQ_I(irq),
        .RETURN_I(ret), .RETURN_PSW_I(rp), .NMI_ACK_O(n_ack),
        .IRQ_ACK_O(i_ack), .STACK_WR_O(s_wr), .STACK_WDATA_O(s_wd),
        .CTX_SWITCH_I(ctx), .CTX_PC_I(pc), .CTX_BANK_I(cb), .DEC_BRANCH_NONZERO_I(dec_branch_nonzero),
        .DEC_BRANCH_NONZERO_HIGH_I(d_hi), .STR_STEP_I(step), .BRANCH_O(br),
        .COUNT_ZERO_O(zero), .UPUSH_I(upush), .UPOP_I(upop),
        .USTACK_ADDR_O(ua));
    bgfs_cpu_model cpu (.clk_i(clk), .init_i(init), .base_i(20'h0FEE0),
        .sp_load_o(sp_ld), .sp_wdata_o(sp_wd));
    always #12.5 clk = ~clk;
    task automatic cyc;
        @(posedge clk);
        #1;
    endtask : cyc
    task automatic pulse(ref logic s);
        cyc;
        s = 1'b1;
        cyc;
        s = 1'b0;
    endtask : pulse
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    task automatic reg_op(input logic w, input bgfs_size_type s,
                          input logic [3:0] n, input logic a,
                          input logic [31:0] d);
        cyc;
        {wr, rd, sel, al} = {w, !w, n, a};
        sz = s;
        wd = d;
        cyc;
        {wr, rd} = 2'h0;
    endtask : reg_op
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    initial begin
        {rst_n, rd, wr, al, m_rd, m_wr, hi, p_wr, b_sel, push, pop} = '0;
        {nmi, irq, ret, ctx, dec_branch_nonzero, d_hi, step, upush, upop, init} = '0;
        {sel, wd, ma, pw, rp, mw, bn, cb, nb, pc} = '0;
        sz = SZ_BYTE;
        rows[0] = '{SZ_PAIR, 4'h0, 32'h5A3C, SZ_BYTE, 4'h1, 32'h5A};
        rows[1] = '{SZ_WIDE, 4'h0, 32'h11223344, SZ_PAIR, 4'h0, 32'h1122};
        rows[2] = '{SZ_PTR, 4'h2, 32'hABCDEF, SZ_PAIR, 4'h6, 32'hCDEF};
        rows[3] = '{SZ_PAIR, 4'h6, 32'h5566, SZ_WIDE, 4'h0, 32'h11225566};
        repeat (2) cyc;
        rst_n = 1'b1;
        chk("bank", 3'h0, bank);
        chk("sp_valid", 1'b0, sp_ok);
        pulse(irq);
        chk("irq_ack", 1'b0, i_ack);
        pulse(nmi);
        chk("nmi_ack", 1'b1, n_ack);
        pulse(init);
        for (int i = 0; i < 8 && sp_ok !== 1'b1; i++)
            cyc;
        chk("sp_valid", 1'b1, sp_ok);
        chk("sp", 24'h00FEE0, sp);
        nb = 2'h2;
        pulse(push);
        chk("stack_addr", 24'h00FEDE, sa);
        pulse(pop);
        chk("sp", 24'h00FEE0, sp);
        pw = 16'h0081;
        pulse(p_wr);
        pulse(irq);
        chk("stack_data", 16'h0081, s_wd);
        chk("stack_wr", 1'b1, s_wr);
        chk("irq_ack", 1'b1, i_ack);
        chk("stack_addr", 24'h00FEDE, sa);
        rp = 16'h3081;
        pulse(ret);
        chk("bank", 3'h3, bank);
        pulse(b_sel);
        foreach (rows[i]) begin
            reg_op(1'b1, rows[i].ws, rows[i].wn, 1'b0, rows[i].wd);
            reg_op(1'b0, rows[i].rs, rows[i].rn, 1'b0, 32'h0);
            chk("reg_rdata", rows[i].ex, rdat);
        end
        ma = 24'h00FEF1;
        pulse(m_rd);
        chk("mem_data", 8'h11, mr);
        hi = 1'b1;
        pulse(m_rd);
        chk("mem_hit", 1'b0, hit);
        ma = 24'h0FFEF1;
        pulse(m_rd);
        chk("mem_hit", 1'b1, hit);
        {hi, ma, mw} = {1'b0, 24'h00FEF2, 8'h02};
        pulse(m_wr);
        pulse(dec_branch_nonzero);
        chk("branch", 1'b1, br);
        pulse(dec_branch_nonzero);
        chk("branch", 1'b0, br);
        reg_op(1'b1, SZ_BYTE, 4'h2, 1'b0, 32'h1);
        pulse(step);
        chk("count_zero", 1'b1, zero);
        pw = 16'h00A0;
        pulse(p_wr);
        reg_op(1'b1, SZ_BYTE, 4'h1, 1'b1, 32'h77);
        reg_op(1'b0, SZ_BYTE, 4'h5, 1'b0, 32'h0);
        chk("alias_reg", 8'h77, rdat);
        reg_op(1'b0, SZ_BYTE, 4'h1, 1'b0, 32'h0);
        chk("abs_reg", 8'h11, rdat);
        {pc, cb} = {20'hABCDE, 3'h3};
        pulse(ctx);
        chk("bank", 3'h3, bank);
        pulse(b_sel);
        reg_op(1'b0, SZ_PAIR, 4'h2, 1'b0, 32'h0);
        chk("ctx_low", 16'hBCDE, rdat);
        reg_op(1'b0, SZ_PAIR, 4'h3, 1'b0, 32'h0);
        chk("ctx_high", 16'h0AA0, rdat);
        bn = 3'h7;
        pulse(b_sel);
        chk("bank_field", 3'h7, processor_status_word[14:12]);
        reg_op(1'b1, SZ_BYTE, 4'h9, 1'b0, 32'h3C);
        ma = 24'h00FE89;
        pulse(m_rd);
        chk("mem_data", 8'h3C, mr);
        reg_op(1'b1, SZ_PTR, 4'h1, 1'b0, 32'h001000);
        pulse(upush);
        chk("ustack", 24'h000FFE, ua);
        summarize;
    end
endmodule : testbench
